// ---- rtl/dci_slave.sv ----
// two-wire slave that loads and reads back the converter holding register
// Summary of operation
// [R01] 12-bit code is unsigned straight binary
// [R02] standard and fast speeds behave identically
// [R03] zero pulls low, one releases the line
// [R04] acknowledge own address, release otherwise
// [R05] acknowledge every received write data byte
// [R06] master acks upper byte, nacks last
// [R07] start is SDA fall while SCL high
// [R08] start followed by address and direction
// [R09] repeated start readdresses, speed mode kept
// [R10] stop is SDA rise with SCL high
// [R11] write sends upper then lower byte
// [R12] word loads register after lower byte ack
// [R13] consecutive byte pairs accepted without readdressing
// [R14] read drives upper then lower byte
// [R15] master code is not acknowledged
// [R16] master raises speed then repeated start
// [R17] repeated start in fast mode stays fast
// [R18] stop ends high-speed mode
// [R19] broadcast address also acknowledged
// [R20] address pins latched at first direct addressing
// [R21] register clears to zero at power-up
// [R22] unmatched address ignored until next start
// [R23] partial word discarded on stop or restart
`include "dci_map.svh"
`default_nettype none
module dci_slave
	import dci_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_n,
	input wire logic [1:0] address_select_pin_low,
	input wire logic [1:0] address_select_pin_high,
	output logic [15:0] dacWord,
	output logic [11:0] dacCode,
	output logic dacUpdate,
	output logic hsMode
);
	logic [1:0] sclSync_r;
	logic [1:0] sdaSync_r;
	logic sclD_r;
	logic sdaD_r;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	dci_state_t state_r;
	logic [2:0] bitCnt_r;
	logic [7:0] shift_r;
	logic [7:0] rxByte;
	logic isRead_r;
	logic lowByte_r;
	logic [7:0] upper_r;
	logic [15:0] dacWord_r;
	logic addrLocked_r;
	logic [6:0] ownAddr_r;
	logic [6:0] pinAddr;
	logic hsMode_r;
	logic drvLow_r;
	logic addrDirect;
	logic addrMatch;
	logic [1:0] pinCount;
	logic [3:0] pinSync1_r;
	logic [3:0] pinSync2_r;

	// two flops on each pin before any logic looks at them
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			sclD_r <= 1'b1;
			sdaD_r <= 1'b1;
		end else begin
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			sclD_r <= sclSync_r[1];
			sdaD_r <= sdaSync_r[1];
		end
	end

	assign sclRise = sclSync_r[1] & ~sclD_r;
	assign sclFall = ~sclSync_r[1] & sclD_r;
	assign startCond = sclSync_r[1] & sclD_r & sdaD_r & ~sdaSync_r[1]; // [R07]
	assign stopCond = sclSync_r[1] & sclD_r & ~sdaD_r & sdaSync_r[1]; // [R10]
	assign rxByte = {shift_r[6:0], sdaSync_r[1]};

	// straps are pins too, so they pass two flops like scl and sda
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pinSync1_r <= `DCI_PIN_RESET;
			pinSync2_r <= `DCI_PIN_RESET;
		end else begin
			pinSync1_r <= {address_select_pin_high, address_select_pin_low};
			pinSync2_r <= pinSync1_r;
		end
	end

	// pin-strapped address; the high pin picks the base, the low pin sets bit 0 or bit 1
	always_comb begin
		pinAddr = `DCI_BASE_FLOAT;
		case (pinSync2_r[3:2])
			`DCI_PIN_GND: pinAddr = `DCI_BASE_GND;
			`DCI_PIN_VA: pinAddr = `DCI_BASE_VA;
			default: pinAddr = `DCI_BASE_FLOAT;
		endcase
		pinCount = pinSync2_r[1:0];
		case (pinCount)
			`DCI_PIN_GND: pinAddr = pinAddr | 7'h01;
			`DCI_PIN_VA: pinAddr = pinAddr | 7'h02;
			default: pinAddr = pinAddr;
		endcase
	end

	assign addrDirect = rxByte[7:1] == (addrLocked_r ? ownAddr_r : pinAddr);
	assign addrMatch = addrDirect | (rxByte[7:1] == `DCI_BCAST_ADDR); // [R19]

	// lock the strapped address once it has been used directly
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			addrLocked_r <= 1'b0;
			ownAddr_r <= 7'h00;
		end else if (!addrLocked_r && state_r == DCI_ADDR && sclRise
				&& bitCnt_r == `DCI_BIT_LAST && addrDirect) begin
			addrLocked_r <= 1'b1; // [R20]
			ownAddr_r <= pinAddr;
		end
	end

	// speed mode: master code arms fast mode, restarts keep it, stop ends it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hsMode_r <= 1'b0;
		end else if (stopCond) begin
			hsMode_r <= 1'b0; // [R18]
		end else if (state_r == DCI_ADDR && sclRise && bitCnt_r == `DCI_BIT_LAST
				&& rxByte[7:3] == `DCI_HS_CODE_HI) begin
			hsMode_r <= 1'b1; // [R15]
		end
	end

	// byte engine; standard and fast speeds need no distinction here
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= DCI_IDLE;
			bitCnt_r <= `DCI_BIT_FIRST;
			shift_r <= 8'h00;
			isRead_r <= 1'b0;
			lowByte_r <= 1'b0;
			upper_r <= 8'h00;
		end else if (startCond) begin
			state_r <= DCI_ADDR; // [R08] [R09] [R17] [R23]
			bitCnt_r <= `DCI_BIT_FIRST;
			lowByte_r <= 1'b0;
		end else if (stopCond) begin
			state_r <= DCI_IDLE; // [R10] [R23]
		end else begin
			case (state_r)
				DCI_ADDR, DCI_RX: begin
					if (sclRise) begin
						shift_r <= rxByte;
						bitCnt_r <= bitCnt_r + 3'h1;
						if (bitCnt_r == `DCI_BIT_LAST) begin
							if (state_r == DCI_ADDR) begin
								isRead_r <= rxByte[0];
								lowByte_r <= 1'b0;
								state_r <= addrMatch ? DCI_ADDR_ACK : DCI_IGNORE; // [R04] [R22]
							end else begin
								state_r <= DCI_RX_ACK; // [R05]
							end
						end
					end
				end
				DCI_ADDR_ACK: begin
					if (sclFall && drvLow_r) begin
						state_r <= isRead_r ? DCI_TX : DCI_RX;
						shift_r <= dacWord_r[15:8]; // [R14]
					end
				end
				DCI_RX_ACK: begin
					if (sclFall && drvLow_r) begin
						state_r <= DCI_RX; // [R13]
						lowByte_r <= ~lowByte_r; // [R11]
						if (!lowByte_r) begin
							upper_r <= shift_r;
						end
					end
				end
				DCI_TX: begin
					if (sclFall) begin
						shift_r <= {shift_r[6:0], 1'b1};
						bitCnt_r <= bitCnt_r + 3'h1;
						if (bitCnt_r == `DCI_BIT_LAST) begin
							state_r <= DCI_TX_ACK;
						end
					end
				end
				DCI_TX_ACK: begin
					if (sclRise) begin
						// master nack, or any answer after the lower byte, ends the read
						if (sdaSync_r[1] || lowByte_r) begin
							state_r <= DCI_IGNORE; // [R06]
						end
						lowByte_r <= 1'b1;
					end else if (sclFall) begin
						// lower byte starts on the fall that closes the ack clock
						state_r <= DCI_TX;
						bitCnt_r <= `DCI_BIT_FIRST;
						shift_r <= dacWord_r[7:0]; // [R14]
					end
				end
				default: begin
					state_r <= state_r;
				end
			endcase
		end
	end

	// ack phase: drive low from the falling edge that opens the ninth clock
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			drvLow_r <= 1'b0;
		end else if (startCond || stopCond) begin
			drvLow_r <= 1'b0;
		end else if (sclFall) begin
			case (state_r)
				DCI_ADDR_ACK: begin
					// second fall releases a write ack or puts out the read msb
					drvLow_r <= !drvLow_r || (isRead_r && !dacWord_r[15]); // [R04] [R14]
				end
				DCI_RX_ACK: begin
					drvLow_r <= !drvLow_r; // [R05]
				end
				DCI_TX: begin
					// shift register still holds the bit just finished
					drvLow_r <= (bitCnt_r != `DCI_BIT_LAST) && !shift_r[6]; // [R14]
				end
				DCI_TX_ACK: begin
					drvLow_r <= !dacWord_r[7]; // [R14]
				end
				default: begin
					drvLow_r <= 1'b0;
				end
			endcase
		end
	end

	// holding register, loaded only after the lower byte is acknowledged
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dacWord_r <= `DCI_WORD_RESET; // [R21]
			dacUpdate <= 1'b0;
		end else begin
			dacUpdate <= 1'b0;
			if (state_r == DCI_RX_ACK && sclFall && drvLow_r && lowByte_r) begin
				dacWord_r <= {upper_r, shift_r}; // [R12]
				dacUpdate <= 1'b1;
			end
		end
	end

	assign sdaOut = 1'b0; // [R03]
	assign sdaOe_n = ~drvLow_r; // [R03]
	assign dacWord = dacWord_r;
	assign dacCode = dacWord_r[`DCI_CODE_MSB:0]; // [R01]
	assign hsMode = hsMode_r; // [R02]

	word_load_a: assert property (@(posedge mclk) disable iff (!resetn) // [R12]
		dacUpdate |-> $past(state_r) == DCI_RX_ACK && $past(lowByte_r)
			&& dacWord == {$past(upper_r), $past(shift_r)})
		else $error("word loaded before lower byte");
	tx_release_a: assert property (@(posedge mclk) disable iff (!resetn) // [R14]
		state_r == DCI_TX_ACK |-> sdaOe_n)
		else $error("sda held during master answer");
	ack_release_a: assert property (@(posedge mclk) disable iff (!resetn) // [R22]
		state_r == DCI_IGNORE |-> sdaOe_n)
		else $error("sda driven while ignoring");
	stop_hs_a: assert property (@(posedge mclk) disable iff (!resetn) // [R18]
		stopCond |=> !hsMode)
		else $error("high speed survives stop");
	stop_idle_a: assert property (@(posedge mclk) disable iff (!resetn) // [R10]
		stopCond |=> state_r == DCI_IDLE)
		else $error("stop not seen");
	start_addr_a: assert property (@(posedge mclk) disable iff (!resetn) // [R09]
		startCond |=> state_r == DCI_ADDR && bitCnt_r == 3'h0)
		else $error("restart not readdressing");
	restart_hs_a: assert property (@(posedge mclk) disable iff (!resetn) // [R17]
		startCond && hsMode |=> hsMode)
		else $error("restart dropped high speed");
	code_map_a: assert property (@(posedge mclk) disable iff (!resetn) // [R01]
		dacCode == dacWord[11:0])
		else $error("code mismatch");
	lock_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // [R20]
		addrLocked_r |=> addrLocked_r && $stable(ownAddr_r))
		else $error("address unlocked");
	cover_write_c: cover property (@(posedge mclk) disable iff (!resetn) dacUpdate);
	cover_hs_c: cover property (@(posedge mclk) disable iff (!resetn) $rose(hsMode));
	cover_read_c: cover property (@(posedge mclk) disable iff (!resetn) state_r == DCI_TX_ACK);
endmodule : dci_slave
`default_nettype wire

// ---- shared/dci_map.svh ----
// register and protocol constants for the converter two-wire slave
`ifndef DCI_MAP_SVH
`define DCI_MAP_SVH
`define DCI_BCAST_ADDR 7'h48
`define DCI_HS_CODE_HI 5'h01
`define DCI_WORD_RESET 16'h0000
`define DCI_BIT_LAST 3'h7
`define DCI_BIT_FIRST 3'h0
`define DCI_CODE_MSB 11
`define DCI_PIN_GND 2'h0
`define DCI_PIN_VA 2'h1
`define DCI_PIN_FLOAT 2'h2
`define DCI_PIN_RESET 4'hA
`define DCI_BASE_FLOAT 7'h0C
`define DCI_BASE_GND 7'h08
`define DCI_BASE_VA 7'h4C
`endif

// ---- shared/dci_pkg.sv ----
// types for the converter two-wire slave
`default_nettype none
package dci_pkg;
	typedef enum logic [2:0] {
		DCI_IDLE,
		DCI_ADDR,
		DCI_ADDR_ACK,
		DCI_RX,
		DCI_RX_ACK,
		DCI_TX,
		DCI_TX_ACK,
		DCI_IGNORE
	} dci_state_t;
endpackage : dci_pkg
`default_nettype wire

// ---- tb/dci_master.sv ----
// two-wire bus master model facing the converter slave
`default_nettype none
module dci_master (
	input wire logic mclk,
	input wire logic sdaWire,
	output logic scl,
	output logic sdaLow
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// phase length in mclk; the fast mode value still clears the synchroniser
	int ph = 8;
	task automatic hold();
		repeat (ph) @(posedge mclk);
	endtask : hold
	task automatic start();
		hold();
		sdaLow <= 1'b0;
		hold();
		scl <= 1'b1;
		hold();
		sdaLow <= 1'b1;
		hold();
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		hold();
		sdaLow <= 1'b1;
		hold();
		scl <= 1'b1;
		hold();
		sdaLow <= 1'b0;
		hold();
	endtask : stop
	// a one only releases the line, never drives it high
	task automatic bitx(input logic b, output logic s);
		hold();
		sdaLow <= ~b;
		hold();
		scl <= 1'b1;
		hold();
		s = sdaWire;
		scl <= 1'b0;
	endtask : bitx
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
	endtask : xfer
endmodule : dci_master
`default_nettype wire

// ---- tb/dci_slave_tb_top.sv ----
// self-checking bench for the converter two-wire slave
`default_nettype none
module dci_slave_tb_top;
	import dci_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, resetn, scl, sdaLow, sdaOut, sdaOe_n, hsMode, dacUpdate, s;
	logic [1:0] pinLo, pinHi;
	logic [15:0] dacWord, w;
	logic [11:0] dacCode;
	logic [7:0] q;
	logic [6:0] own;
	int miscompares = 0;
	int comparisons = 0;
	int updCnt = 0;
	wire logic sdaWire = !sdaLow && (sdaOe_n || sdaOut);
	dci_slave i_dci_slave (.mclk(mclk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .address_select_pin_low(pinLo),
		.address_select_pin_high(pinHi), .dacWord(dacWord), .dacCode(dacCode),
		.dacUpdate(dacUpdate), .hsMode(hsMode));
	dci_master i_dci_master (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
	always @(posedge mclk) begin
		if (dacUpdate === 1'b1)
			updCnt <= updCnt + 1;
	end
	function automatic logic [6:0] addrOf(logic [1:0] hi, logic [1:0] lo);
		addrOf = (hi == 2'h0) ? 7'h08 : (hi == 2'h1) ? 7'h4C : 7'h0C;
		return addrOf + ((lo == 2'h0) ? 7'h01 : (lo == 2'h1) ? 7'h02 : 7'h00);
	endfunction : addrOf
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s exp %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wb(logic [7:0] d, logic expAck);
		i_dci_master.xfer(d, q);
		i_dci_master.bitx(1'b1, s);
		check("ack", 16'(s), 16'(expAck));
	endtask : wb
	task automatic addr(logic [6:0] a, logic rw, logic expAck);
		i_dci_master.start();
		wb({a, rw}, expAck);
	endtask : addr
	task automatic wrWord(logic [15:0] d);
		int n;
		n = updCnt;
		wb(d[15:8], 1'b0);
		wb(d[7:0], 1'b0);
		i_dci_master.hold();
		check("word", dacWord, d);
		check("code", 16'(dacCode), 16'(d[11:0]));
		check("update", 16'(updCnt - n), 16'h0001);
	endtask : wrWord
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		repeat (90000) @(posedge mclk);
		miscompares++;
		summarize();
	end
	initial begin
		resetn = 1'b0;
		pinLo = 2'h2;
		pinHi = 2'h2;
		void'($urandom(3));
		repeat (5) @(posedge mclk);
		pinLo <= 2'($urandom % 3);
		pinHi <= 2'($urandom % 3);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		own = addrOf(pinHi, pinLo);
		check("reset", dacWord, 16'h0000);
		check("release", 16'(sdaOe_n), 16'h0001);
		check("sdaOut", 16'(sdaOut), 16'h0000);
		check("hs", 16'(hsMode), 16'h0000);
		addr(own ^ 7'h01, 1'b0, 1'b1);
		wb(8'h00, 1'b1);
		i_dci_master.stop();
		addr(own, 1'b0, 1'b0);
		wrWord(16'h0FFF);
		w = 16'($urandom);
		wrWord(w);
		wb(8'hA5, 1'b0);
		addr(own, 1'b1, 1'b0);
		check("partial", dacWord, w);
		i_dci_master.xfer(8'hFF, q);
		check("upper", 16'(q), 16'(w[15:8]));
		i_dci_master.bitx(1'b0, s);
		i_dci_master.xfer(8'hFF, q);
		check("lower", 16'(q), 16'(w[7:0]));
		i_dci_master.bitx(1'b1, s);
		i_dci_master.stop();
		addr(7'h48, 1'b0, 1'b0);
		wrWord(16'($urandom));
		i_dci_master.stop();
		pinLo <= 2'((pinLo + 2'h1) % 3);
		addr(own, 1'b0, 1'b0);
		i_dci_master.stop();
		i_dci_master.start();
		wb({5'h01, 3'($urandom)}, 1'b1);
		check("hs", 16'(hsMode), 16'h0001);
		i_dci_master.ph = 5;
		addr(own, 1'b0, 1'b0);
		check("hs", 16'(hsMode), 16'h0001);
		wrWord(16'($urandom));
		i_dci_master.stop();
		i_dci_master.ph = 8;
		check("hs", 16'(hsMode), 16'h0000);
		summarize();
	end
endmodule : dci_slave_tb_top
`default_nettype wire
